// [hdl/wfad_defines.vh]
// Constants for the word format and address decode block
`ifndef WFAD_DEFINES_VH
`define WFAD_DEFINES_VH

// ==========================================================
// Word field positions
`define WFAD_SIGN_BIT 15
`define WFAD_IND_BIT 15
`define WFAD_ADDR_HI 14
`define WFAD_OP_HI 15
`define WFAD_OP_LO 12
`define WFAD_MODE_HI 11
`define WFAD_MODE_LO 9
`define WFAD_ACT_HI 8
`define WFAD_ACT_LO 0

// ==========================================================
// Op-code values of the non-addressing groups
`define WFAD_OP_SHIFT_CTL 4'h0
`define WFAD_OP_IO 4'h8

// ==========================================================
// Instruction classes
`define WFAD_CLS_SHIFT_CTL 2'h0
`define WFAD_CLS_IO 2'h1
`define WFAD_CLS_ADDR 2'h2

// ==========================================================
// Addressing modes as presented
`define WFAD_AM_DIRECT 3'h0
`define WFAD_AM_RELATIVE 3'h1
`define WFAD_AM_INDEX_X 3'h2
`define WFAD_AM_INDEX_B 3'h3
`define WFAD_AM_INDIRECT 3'h4
`define WFAD_AM_NONE 3'h7

// ==========================================================
// Mode field codes
`define WFAD_MF_RELATIVE 3'h4
`define WFAD_MF_INDEX_X 3'h5
`define WFAD_MF_INDEX_B 3'h6
`define WFAD_MF_INDIRECT 3'h7

// ==========================================================
// Register word indices (byte offset is four times the value)
`define WFAD_OFS_CTRL 4'h0
`define WFAD_OFS_STATUS 4'h1
`define WFAD_OFS_EA 4'h2
`define WFAD_OFS_LEVELS 4'h3
`define WFAD_OFS_DATA 4'h4
`define WFAD_OFS_DATA_INFO 4'h5
`define WFAD_ADDR_LO 2
`define WFAD_IDX_UNMAPPED 4'hF

// ==========================================================
// Reset values and responses
`define WFAD_CTRL_RST 2'h3
`define WFAD_RESP_OKAY 2'h0
`define WFAD_RESP_SLVERR 2'h2
`define WFAD_LEVELS_MAX 16'hFFFF

`endif

// [hdl/wfad_field_split.v]
// Instruction word field split and class and mode decode
`timescale 1ns/1ps
`include "wfad_defines.vh"

module wfad_field_split (
  // Instruction word
  input wire [15:0] word_i,
  // Decoded fields
  output wire [3:0] opcode_o,
  output wire [2:0] mode_field_o,
  output wire [8:0] action_o,
  output reg [1:0] class_o,
  output reg [2:0] amode_o
);

  // ========================================================
  // Field split
  assign opcode_o = word_i[`WFAD_OP_HI:`WFAD_OP_LO];
  assign mode_field_o = word_i[`WFAD_MODE_HI:`WFAD_MODE_LO];
  assign action_o = word_i[`WFAD_ACT_HI:`WFAD_ACT_LO];

  // ========================================================
  // Class and addressing mode
  always @* begin
    class_o = `WFAD_CLS_ADDR;
    amode_o = `WFAD_AM_NONE;
    if (opcode_o == `WFAD_OP_SHIFT_CTL) begin
      class_o = `WFAD_CLS_SHIFT_CTL;
    end else if (opcode_o == `WFAD_OP_IO) begin
      class_o = `WFAD_CLS_IO;
    end else begin
      case (mode_field_o)
        `WFAD_MF_RELATIVE: amode_o = `WFAD_AM_RELATIVE;
        `WFAD_MF_INDEX_X: amode_o = `WFAD_AM_INDEX_X;
        `WFAD_MF_INDEX_B: amode_o = `WFAD_AM_INDEX_B;
        `WFAD_MF_INDIRECT: amode_o = `WFAD_AM_INDIRECT;
        default: amode_o = `WFAD_AM_DIRECT;
      endcase
    end
  end

endmodule // wfad_field_split

// [hdl/wfad_ea_calc.v]
// Effective address calculation for single-word addressing
`timescale 1ns/1ps
`include "wfad_defines.vh"

module wfad_ea_calc (
  // Decoded fields
  input wire [2:0] amode_i,
  input wire [2:0] mode_field_i,
  input wire [8:0] action_i,
  // Datapath registers
  input wire [15:0] pc_i,
  input wire [15:0] x_reg_i,
  input wire [15:0] b_reg_i,
  // Result
  output reg [14:0] ea_o
);

  // Add the zero-extended action field to a 15-bit base
  function [14:0] wfad_add_action;
    input [14:0] base;
    input [8:0] act;
    begin
      wfad_add_action = base + {6'h00, act};
    end
  endfunction

  // ========================================================
  // Address forming per mode
  always @* begin
    case (amode_i)
      `WFAD_AM_DIRECT: ea_o = {4'h0, mode_field_i[1:0], action_i};
      `WFAD_AM_RELATIVE: ea_o = wfad_add_action(pc_i[14:0] + 15'h0001, action_i);
      `WFAD_AM_INDEX_X: ea_o = wfad_add_action(x_reg_i[14:0], action_i);
      `WFAD_AM_INDEX_B: ea_o = wfad_add_action(b_reg_i[14:0], action_i);
      `WFAD_AM_INDIRECT: ea_o = {6'h00, action_i};
      default: ea_o = 15'h0000;
    endcase
  end

endmodule // wfad_ea_calc

// [hdl/wfad_top.v]
// Word format and address decode top with indirect chase and register slave
// Behaviour
// - Data word bit 15 is the sign; bits 0-14 carry the value.
// - Negative values are two's complement; zero counts as positive.
// - Address word bit 15 set means the location holds another address word.
// - Keep fetching address words while bit 15 is set, one read per level.
// - Op-code is the top four bits of each instruction word.
// - Three-bit mode field below the op-code selects address or operating mode.
// - Low nine-bit action field meaning depends on instruction type.
// - For double-word instructions only the first word is field decoded.
// - Op-codes octal 01-07 and 11-17 are single-word addressing instructions.
// - Mode top bit clear direct; 100 relative; 101 index X; 110 index B.
// - Direct address joins low two mode bits above the action field.
// - Op-code 00 is shift/control/register change; 10 is input/output.
// - Relative address is action field plus program counter plus one.
// - Indexed adds action to X or B; mode 7 names the pointer location.
`timescale 1ns/1ps
`include "wfad_defines.vh"

module wfad_top (
  // Clock and reset
  input wire mclk_i,
  input wire reset_i,
  // Instruction input from fetch
  input wire instr_valid_i,
  input wire instr_second_i,
  input wire [15:0] instr_word_i,
  output wire instr_ready_o,
  // Datapath registers
  input wire [15:0] pc_i,
  input wire [15:0] x_reg_i,
  input wire [15:0] b_reg_i,
  // Decoded instruction
  output wire dec_valid_o,
  output wire [1:0] class_o,
  output wire [2:0] amode_o,
  output wire [3:0] opcode_o,
  output wire [2:0] mode_field_o,
  output wire [8:0] action_o,
  // Effective address
  output wire ea_valid_o,
  output wire [14:0] ea_o,
  // Address word read port
  output wire mem_req_o,
  output wire [14:0] mem_addr_o,
  input wire mem_rvalid_i,
  input wire [15:0] mem_rdata_i,
  // AXI4-Lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  // ========================================================
  // States
  localparam ST_IDLE = 1'b0;
  localparam ST_CHASE = 1'b1;

  // ========================================================
  // Declarations
  wire [3:0] sp_opcode;
  wire [2:0] sp_mode_field;
  wire [8:0] sp_action;
  wire [1:0] sp_class;
  wire [2:0] sp_amode;
  wire [14:0] calc_ea;
  wire accept;
  wire start_chase;
  reg state_reg;
  reg ready_reg;
  reg dec_valid_reg;
  reg [1:0] class_reg;
  reg [2:0] amode_reg;
  reg [3:0] opcode_reg;
  reg [2:0] mode_field_reg;
  reg [8:0] action_reg;
  reg ea_valid_reg;
  reg [14:0] ea_reg;
  reg mem_req_reg;
  reg [14:0] mem_addr_reg;
  reg [15:0] levels_reg;
  reg [1:0] ctrl_reg;
  reg [15:0] data_reg;
  reg awready_reg;
  reg wready_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [3:0] aw_idx_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rd_value;
  reg rd_hit;
  wire ctrl_enable;
  wire ctrl_chase;
  wire data_neg;
  wire [15:0] data_mag;

  // ========================================================
  // Field split and address forming
  wfad_field_split i_wfad_field_split (
    .word_i(instr_word_i),
    .opcode_o(sp_opcode),
    .mode_field_o(sp_mode_field),
    .action_o(sp_action),
    .class_o(sp_class),
    .amode_o(sp_amode)
  );

  wfad_ea_calc i_wfad_ea_calc (
    .amode_i(sp_amode),
    .mode_field_i(sp_mode_field),
    .action_i(sp_action),
    .pc_i(pc_i),
    .x_reg_i(x_reg_i),
    .b_reg_i(b_reg_i),
    .ea_o(calc_ea)
  );

  // ========================================================
  // Control bits
  assign ctrl_enable = ctrl_reg[0];
  assign ctrl_chase = ctrl_reg[1];

  // Second words carry no fields and are passed over
  assign accept = instr_valid_i & ready_reg & ~instr_second_i;
  assign start_chase = accept & ctrl_chase & (sp_amode == `WFAD_AM_INDIRECT);

  // ========================================================
  // Decode register and indirect chase
  always @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
      dec_valid_reg <= 1'b0;
      class_reg <= `WFAD_CLS_SHIFT_CTL;
      amode_reg <= `WFAD_AM_NONE;
      opcode_reg <= 4'h0;
      mode_field_reg <= 3'h0;
      action_reg <= 9'h000;
      ea_valid_reg <= 1'b0;
      ea_reg <= 15'h0000;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= 15'h0000;
      levels_reg <= 16'h0000;
    end else begin
      dec_valid_reg <= 1'b0;
      ea_valid_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          ready_reg <= ctrl_enable & ~start_chase;
          if (accept) begin
            // Decoded fields leave now; for addressing words the address too, unless a chase starts
            dec_valid_reg <= 1'b1;
            class_reg <= sp_class;
            amode_reg <= sp_amode;
            opcode_reg <= sp_opcode;
            mode_field_reg <= sp_mode_field;
            action_reg <= sp_action;
            ea_reg <= calc_ea;
            if (start_chase) begin
              // Pointer location named by the action field
              state_reg <= ST_CHASE;
              mem_req_reg <= 1'b1;
              mem_addr_reg <= calc_ea;
              levels_reg <= 16'h0000;
            end else begin
              ea_valid_reg <= (sp_class == `WFAD_CLS_ADDR);
            end
          end
        end
        ST_CHASE: begin
          ready_reg <= 1'b0;
          if (mem_rvalid_i) begin
            // One read per level of indirection
            if (levels_reg != `WFAD_LEVELS_MAX) begin
              levels_reg <= levels_reg + 16'h0001;
            end
            if (mem_rdata_i[`WFAD_IND_BIT]) begin
              mem_addr_reg <= mem_rdata_i[`WFAD_ADDR_HI:0];
            end else begin
              ea_reg <= mem_rdata_i[`WFAD_ADDR_HI:0];
              ea_valid_reg <= 1'b1;
              mem_req_reg <= 1'b0;
              state_reg <= ST_IDLE;
              ready_reg <= ctrl_enable;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          mem_req_reg <= 1'b0;
          ready_reg <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================
  // Sign and magnitude of the software data word
  assign data_neg = data_reg[`WFAD_SIGN_BIT];
  assign data_mag = data_neg ? (~data_reg + 16'h0001) : data_reg;

  // ========================================================
  // Write channel: address and data taken in either order
  always @(posedge mclk_i) begin
    if (reset_i) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `WFAD_RESP_OKAY;
      ctrl_reg <= `WFAD_CTRL_RST;
      data_reg <= 16'h0000;
    end else begin
      awready_reg <= ~aw_got_reg & ~bvalid_reg & ~(s_axi_awvalid & awready_reg);
      wready_reg <= ~w_got_reg & ~bvalid_reg & ~(s_axi_wvalid & wready_reg);
      if (s_axi_awvalid & awready_reg) begin
        aw_got_reg <= 1'b1;
        // A high address bit set forces an unmapped index, so nothing aliases
        if (s_axi_awaddr[31:`WFAD_ADDR_LO+4] != 26'h0000000) begin
          aw_idx_reg <= `WFAD_IDX_UNMAPPED;
        end else begin
          aw_idx_reg <= s_axi_awaddr[`WFAD_ADDR_LO+3:`WFAD_ADDR_LO];
        end
      end
      if (s_axi_wvalid & wready_reg) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      // Perform the write once both halves are held
      if (aw_got_reg & w_got_reg & ~bvalid_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= `WFAD_RESP_OKAY;
        case (aw_idx_reg)
          `WFAD_OFS_CTRL: begin
            if (wstrb_reg[0]) begin
              ctrl_reg <= wdata_reg[1:0];
            end
          end
          `WFAD_OFS_DATA: begin
            if (wstrb_reg[0]) begin
              data_reg[7:0] <= wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
              data_reg[15:8] <= wdata_reg[15:8];
            end
          end
          `WFAD_OFS_STATUS, `WFAD_OFS_EA, `WFAD_OFS_LEVELS, `WFAD_OFS_DATA_INFO: begin
            bresp_reg <= `WFAD_RESP_OKAY;
          end
          default: bresp_reg <= `WFAD_RESP_SLVERR;
        endcase
      end
      if (bvalid_reg & s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ========================================================
  // Read decode
  always @* begin
    rd_hit = 1'b1;
    rd_value = 32'h00000000;
    case (s_axi_araddr[`WFAD_ADDR_LO+3:`WFAD_ADDR_LO])
      `WFAD_OFS_CTRL: rd_value = {30'h00000000, ctrl_reg};
      `WFAD_OFS_STATUS: rd_value = {20'h00000, 3'h0, ea_valid_reg, 1'b0, amode_reg, class_reg, mem_req_reg,
                                    state_reg};
      `WFAD_OFS_EA: rd_value = {17'h00000, ea_reg};
      `WFAD_OFS_LEVELS: rd_value = {16'h0000, levels_reg};
      `WFAD_OFS_DATA: rd_value = {16'h0000, data_reg};
      `WFAD_OFS_DATA_INFO: rd_value = {15'h0000, data_neg, data_mag};
      default: rd_hit = 1'b0;
    endcase
    if (s_axi_araddr[31:`WFAD_ADDR_LO+4] != 26'h0000000) begin
      rd_hit = 1'b0;
      rd_value = 32'h00000000;
    end
  end

  // ========================================================
  // Read channel
  always @(posedge mclk_i) begin
    if (reset_i) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `WFAD_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalid_reg & ~(s_axi_arvalid & arready_reg);
      if (s_axi_arvalid & arready_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_value;
        rresp_reg <= rd_hit ? `WFAD_RESP_OKAY : `WFAD_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ========================================================
  // Outputs
  assign instr_ready_o = ready_reg;
  assign dec_valid_o = dec_valid_reg;
  assign class_o = class_reg;
  assign amode_o = amode_reg;
  assign opcode_o = opcode_reg;
  assign mode_field_o = mode_field_reg;
  assign action_o = action_reg;
  assign ea_valid_o = ea_valid_reg;
  assign ea_o = ea_reg;
  assign mem_req_o = mem_req_reg;
  assign mem_addr_o = mem_addr_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;

endmodule // wfad_top

// [test/wfad_properties.sv]
// Checker for decode timing, field split, classes and effective address
`timescale 1ns/1ps
module wfad_properties (
  // Clock and reset
  input wire mclk_i,
  input wire reset_i,
  // Instruction side
  input wire instr_valid_i,
  input wire instr_second_i,
  input wire [15:0] instr_word_i,
  input wire instr_ready_o,
  input wire [15:0] pc_i,
  input wire [15:0] x_reg_i,
  input wire [15:0] b_reg_i,
  // Decoded instruction
  input wire dec_valid_o,
  input wire [1:0] class_o,
  input wire [2:0] amode_o,
  input wire [3:0] opcode_o,
  input wire [2:0] mode_field_o,
  input wire [8:0] action_o,
  input wire ea_valid_o,
  input wire [14:0] ea_o,
  // Address word reads
  input wire mem_req_o,
  input wire [14:0] mem_addr_o,
  input wire mem_rvalid_i,
  input wire [15:0] mem_rdata_i
);
  // ==========================================================
  // Helper terms
  wire take = instr_valid_i && instr_ready_o;
  wire acc = take && !instr_second_i;
  wire adec = dec_valid_o && class_o == 2'h2;
  wire hop = mem_req_o && mem_rvalid_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // Decode timing and fields
  a_dec_follows: assert property (acc |=> dec_valid_o && opcode_o == $past(instr_word_i[15:12]))
    else $error("decode pulse or opcode wrong");
  a_fields_split: assert property (acc |=> mode_field_o == $past(instr_word_i[11:9])
    && action_o == $past(instr_word_i[8:0]))
    else $error("mode or action field wrong");
  a_second_dropped: assert property (take && instr_second_i |=> !dec_valid_o)
    else $error("second word decoded");
  a_class_none: assert property (dec_valid_o && opcode_o[2:0] == 3'h0
    |-> class_o == {1'b0, opcode_o[3]} && amode_o == 3'h7)
    else $error("non-addressing class wrong");
  a_class_addr: assert property (dec_valid_o && opcode_o[2:0] != 3'h0 |-> class_o == 2'h2)
    else $error("addressing class wrong");

  // ==========================================================
  // Effective address per mode
  a_direct_ea: assert property (adec && !mode_field_o[2] |-> ea_valid_o && amode_o == 3'h0
    && ea_o == {4'h0, mode_field_o[1:0], action_o})
    else $error("direct address wrong");
  a_rel_ea: assert property (adec && mode_field_o == 3'h4 |-> ea_valid_o && amode_o == 3'h1
    && ea_o == 15'($past(pc_i) + 16'h0001 + action_o))
    else $error("relative address wrong");
  a_index_ea: assert property (adec && (mode_field_o == 3'h5 || mode_field_o == 3'h6)
    |-> ea_valid_o && amode_o == {2'h1, mode_field_o[1]}
    && ea_o == 15'((mode_field_o[0] ? $past(x_reg_i) : $past(b_reg_i)) + action_o))
    else $error("indexed address wrong");
  a_ind_start: assert property (adec && mode_field_o == 3'h7 && mem_req_o
    |-> mem_addr_o == {6'h00, action_o} && !instr_ready_o)
    else $error("pointer read wrong");

  // ==========================================================
  // Indirect chain
  a_chase_next: assert property (hop && mem_rdata_i[15]
    |=> mem_req_o && mem_addr_o == $past(mem_rdata_i[14:0]))
    else $error("chain not followed");
  a_chase_done: assert property (hop && !mem_rdata_i[15]
    |=> ea_valid_o && !mem_req_o && ea_o == $past(mem_rdata_i[14:0]))
    else $error("chain end wrong");
endmodule // wfad_properties

bind wfad_top wfad_properties i_wfad_properties (.*);

// [test/wfad_mem_model.sv]
// Memory model answering address word reads
`timescale 1ns/1ps
module wfad_mem_model (
  // Clock and reset
  input wire mclk_i,
  input wire reset_i,
  // Read request
  input wire mem_req_i,
  input wire [14:0] mem_addr_i,
  input wire [3:0] delay_i,
  // Read answer
  output reg mem_rvalid_o,
  output reg [15:0] mem_rdata_o
);
  reg [15:0] mem [0:32767];
  reg [3:0] wait_reg;
  // Answer after delay_i cycles; data toggles whenever no word is valid
  always @(posedge mclk_i) begin
    if (reset_i) begin
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= 16'hA5A5;
      wait_reg <= 4'h0;
    end else begin
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_rvalid_o) begin
        if (wait_reg == delay_i) begin
          mem_rvalid_o <= 1'b1;
          mem_rdata_o <= mem[mem_addr_i];
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule // wfad_mem_model

// [test/word_format_address_decode_test.sv]
// Self-checking bench for the word format and address decode block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module word_format_address_decode_test;
  logic mclk_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0, instr_second_i = 1'b0;
  logic [15:0] instr_word_i = 16'h0000, pc_i = 16'h0000, x_reg_i = 16'h0000, b_reg_i = 16'h0000;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF, mem_delay = 4'h0;
  wire instr_ready_o, dec_valid_o, ea_valid_o, mem_req_o, mem_rvalid_i;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] class_o, s_axi_bresp, s_axi_rresp;
  wire [2:0] amode_o, mode_field_o;
  wire [3:0] opcode_o;
  wire [8:0] action_o;
  wire [14:0] ea_o, mem_addr_o;
  wire [15:0] mem_rdata_i;
  wire [31:0] s_axi_rdata;
  logic [1:0] rs, cl;
  logic [2:0] am;
  logic [14:0] ea;
  logic dv;
  int failures = 0, cmp_count = 0;
  logic [2:0] exp_am [0:6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
  logic [14:0] exp_ea [0:6] = '{15'h01FF, 15'h03FF, 15'h05FF, 15'h07FF, 15'h1434, 15'h01FE, 15'h02FF};
  logic [15:0] dw [0:3] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
  logic [31:0] di [0:3] = '{32'h0, 32'h7FFF, 32'h18000, 32'h10001};

  // ==========================================================
  // Clock, design and memory
  always #4 mclk_i = ~mclk_i;
  wfad_top i_wfad_top (.*);
  wfad_mem_model i_wfad_mem_model (.mclk_i, .reset_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
    .delay_i(mem_delay), .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));

  // ==========================================================
  // Bus and instruction tasks
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, wd;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    // Each half is released at the edge that takes it; only the watchdog ends a wait
    do begin
      @(posedge mclk_i);
      if (s_axi_awready === 1'b1) ad = 1'b1;
      if (s_axi_wready === 1'b1) wd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end while (!(ad && wd));
    while (s_axi_bvalid !== 1'b1) @(posedge mclk_i);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a);
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk_i); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Offer one word, then capture decode and address once they settle
  task automatic issue(input logic [15:0] w, input logic sec);
    @(posedge mclk_i);
    instr_word_i <= w;
    instr_second_i <= sec;
    instr_valid_i <= 1'b1;
    do @(posedge mclk_i); while (instr_ready_o !== 1'b1);
    instr_valid_i <= 1'b0;
    @(negedge mclk_i);
    dv = dec_valid_o;
    cl = class_o;
    am = amode_o;
    while (!sec && cl === 2'h2 && ea_valid_o !== 1'b1) @(negedge mclk_i);
    ea = ea_o;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    axi_rd(32'h0000_0000);
    `CHK(rd, 32'h0000_0003)
    axi_rd(32'h0000_0040);
    `CHK(rs, 2'h2)
    axi_wr(32'h0000_0040, 32'h0000_0000);
    `CHK(rs, 2'h2)
    $display("test registers done");
    for (int op = 0; op < 16; op++) begin
      issue({op[3:0], 3'h2, 9'h055}, 1'b0);
      `CHK(dv, 1'b1)
      `CHK(cl, (op == 0) ? 2'h0 : (op == 8) ? 2'h1 : 2'h2)
      if (op % 8 != 0) `CHK(ea, 15'h0455)
    end
    $display("test opcodes done");
    @(posedge mclk_i);
    pc_i <= 16'h1234;
    x_reg_i <= 16'h7FFF;
    b_reg_i <= 16'h0100;
    for (int m = 0; m < 7; m++) begin
      issue({4'h3, m[2:0], 9'h1FF}, 1'b0);
      `CHK(am, exp_am[m])
      `CHK(ea, exp_ea[m])
    end
    $display("test modes done");
    i_wfad_mem_model.mem[15'h0005] = 16'h8123;
    i_wfad_mem_model.mem[15'h0123] = 16'h8200;
    i_wfad_mem_model.mem[15'h0200] = 16'h0456;
    for (int d = 0; d < 2; d++) begin
      @(posedge mclk_i);
      mem_delay <= d ? 4'h3 : 4'h0;
      issue(16'h1E05, 1'b0);
      `CHK(am, 3'h4)
      `CHK(ea, 15'h0456)
      axi_rd(32'h0000_000C);
      `CHK(rd, 32'h0000_0003)
    end
    $display("test indirect done");
    issue(16'h1A05, 1'b1);
    `CHK(dv, 1'b0)
    $display("test second word done");
    for (int i = 0; i < 4; i++) begin
      axi_wr(32'h0000_0010, {16'h0000, dw[i]});
      axi_rd(32'h0000_0014);
      `CHK(rd, di[i])
    end
    $display("test sign done");
    axi_wr(32'h0000_0000, 32'h0000_0000);
    repeat (2) @(negedge mclk_i);
    `CHK(instr_ready_o, 1'b0)
    // Enable again with the chase off: the pointer location is the address
    axi_wr(32'h0000_0000, 32'h0000_0001);
    issue(16'h1E05, 1'b0);
    `CHK(am, 3'h4)
    `CHK(ea, 15'h0005)
    $display("test enable done");
    print_verdict;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule // word_format_address_decode_test
